// ### sbf_pkg.sv
// shared constants and carrier types for the spi fault / low-power block
`default_nettype none

package sbf_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_NS   = 20;                        // core_clk period
    localparam int SCLK_HALF_NS  = 80;                        // master serial clock half period
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CORE_CLK_NS; // rounded down, not clamped to at least one

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int         BYTE_BITS  = 8;
    localparam logic [3:0] LAST_BIT   = 4'h7;                 // slave bit index of last bit
    localparam logic [4:0] LAST_EDGE  = 5'h0F;                // master edge index of last edge
    localparam logic [7:0] RST_BYTE   = 8'h00;                // data register after reset
    localparam logic [2:0] HALF_LOAD  = 3'(SCLK_HALF_CYC - 1);

    // configuration carried from software
    typedef struct packed {
        logic system_enable;
        logic master_select;
        logic mode_fault_enable;
        logic single_pin_select;
        logic shared_pin_output_enable;
        logic stop_in_wait;
        logic receive_fault_int_mask;
        logic transmit_int_mask;
        logic match_int_mask;
    } sbf_cfg_t;

    // status flags shown to software
    typedef struct packed {
        logic receive_full_flag;
        logic match_flag;
        logic transmit_empty_flag;
        logic mode_fault_flag;
    } sbf_flags_t;

    // cpu power state
    typedef struct packed {
        logic cpu_wait;
        logic cpu_stop_retain;
        logic cpu_stop_lose;
    } sbf_power_t;

    localparam sbf_cfg_t   CFG_RST   = '0;
    localparam sbf_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b1, 1'b0};

    // master transfer engine states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_XFER
    } sbf_mst_state_t;

endpackage

`default_nettype wire

// ### sbf_sync.sv
// two-flop synchroniser for slow levels and toggles
`default_nettype none

module sbf_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // ------------------------------------------------------------
    // first stage feeds only the second stage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// ### sbf_slave_link.sv
// slave shifter clocked by the external serial clock
`default_nettype none

module sbf_slave_link
    import sbf_pkg::*;
(
    // link clock and resets
    input  wire logic       link_clk,
    input  wire logic       rstn,
    input  wire logic       select_n,
    // serial data
    input  wire logic       din,
    output logic            dout,
    // byte exchange with core domain
    input  wire logic [7:0] tx_byte,
    input  wire logic       load_tgl,
    output logic      [7:0] rx_byte,
    output logic            done_tgl
);

    logic       frame_rstn;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] next_rx;
    logic       next_done;
    logic       ld_meta;
    logic       ld_sync;
    logic       ld_seen;
    logic       next_seen;
    logic [7:0] shifted;

    // bit counter restarts whenever the slave is deselected
    assign frame_rstn = rstn & ~select_n;

    // ------------------------------------------------------------
    // bit counter
    // ------------------------------------------------------------
    always_comb begin
        next_cnt = (cnt == LAST_BIT) ? 4'h0 : cnt + 4'h1;
    end

    always_ff @(posedge link_clk or negedge frame_rstn) begin
        if (!frame_rstn) cnt <= 4'h0;
        else             cnt <= next_cnt;
    end

    // ------------------------------------------------------------
    // shifter; keeps running while the core sleeps
    // ------------------------------------------------------------
    always_comb begin
        shifted   = {sh[6:0], din};
        next_sh   = shifted;
        next_rx   = rx_byte;
        next_done = done_tgl;
        next_seen = ld_seen;
        if (cnt == LAST_BIT) begin
            next_rx   = shifted;
            next_done = ~done_tgl;
            next_seen = ld_sync;
            // new byte only if written; otherwise echo received data
            if (ld_sync != ld_seen) next_sh = tx_byte;
        end
    end

    // garbage-free start: shifter clears with the device reset
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            sh       <= RST_BYTE;
            rx_byte  <= RST_BYTE;
            done_tgl <= 1'b0;
            ld_seen  <= 1'b0;
            ld_meta  <= 1'b0;
            ld_sync  <= 1'b0;
        end else begin
            sh       <= next_sh;
            rx_byte  <= next_rx;
            done_tgl <= next_done;
            ld_seen  <= next_seen;
            ld_meta  <= load_tgl;
            ld_sync  <= ld_meta;
        end
    end

    assign dout = sh[7];

endmodule

`default_nettype wire

// ### sbf_spi_core.sv
// spi unit: shared-pin mode, mode fault, low-power behaviour and flags
//
// What this block does
// - single-pin mode uses only one data pin
// - output enable sets shared pin direction
// - clock out as master, in as slave
// - master with fault enabled: select low faults
// - fault disabled or slave: never raise fault
// - fault aborts, clears master, releases all pins
// - fault in single-pin master clears shared enable
// - status read then control write clears fault
// - disabled in run: core frozen, registers live
// - wait with stop-in-wait halts clock generation
// - master transfer freezes and resumes around wait
// - sleeping slave keeps sending chosen source
// - sleeping slave defers receive copy until exit
// - retaining stop freezes master, slave stays synced
// - losing stop resets config, flags, data and transmit buffer
// - data register reads zero after reset
// - interrupts only while system enabled
// - flag and its mask raise interrupt
// - fault interrupt follows the fault flag
// - full flag blocks later receive copies
// - empty and match flags set on events
// - sleeping slave wakes cpu at byte end
`default_nettype none

module sbf_spi_core
    import sbf_pkg::*;
(
    // clocks and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       serial_clock_pin_in,
    // software configuration and strobes
    input  wire sbf_cfg_t   cfg_in,
    input  wire logic       cfg_wr,
    input  wire logic       status_rd,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       data_rd,
    input  wire logic [7:0] match_value,
    input  wire sbf_power_t power,
    // software view
    output sbf_cfg_t        cfg,
    output sbf_flags_t      flags,
    output logic      [7:0] data_register,
    output logic            irq,
    output logic            wake_irq,
    // serial clock pin
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    // data pins
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    // slave select
    input  wire logic       slave_select_n_in
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic           ss_act;
    logic           miso_s;
    logic           mosi_s;
    logic           done_s;
    logic           done_last;
    logic           done_seen;
    logic           slave_din;
    logic [7:0]     link_rx;
    logic           link_dout;
    logic           link_done;
    logic [7:0]     slv_tx;
    logic           slv_load;
    logic           freeze;
    logic           run;
    logic           is_master;
    logic           fault_hit;
    logic           mst_din;
    logic           mst_done;
    logic           rx_evt;
    logic [7:0]     rx_val;

    sbf_cfg_t       next_cfg;
    sbf_flags_t     next_flags;
    logic [7:0]     next_data;
    logic           arm_rx;
    logic           arm_tx;
    logic           arm_mf;
    logic           next_arm_rx;
    logic           next_arm_tx;
    logic           next_arm_mf;
    logic           next_done_last;
    logic [7:0]     next_slv_tx;
    logic           next_slv_load;

    sbf_mst_state_t st;
    sbf_mst_state_t next_st;
    logic [7:0]     tx_buf;
    logic [7:0]     next_tx_buf;
    logic [7:0]     sh;
    logic [7:0]     next_sh;
    logic           samp;
    logic           next_samp;
    logic [2:0]     half;
    logic [2:0]     next_half;
    logic [4:0]     edge_idx;
    logic [4:0]     next_edge_idx;
    logic           next_sclk;

    logic           next_irq;
    logic           next_wake;
    logic           next_sclk_oe;
    logic           next_mosi_oe;
    logic           next_miso_oe;

    // ------------------------------------------------------------
    // pin and crossing synchronisers
    // ------------------------------------------------------------
    sbf_sync #(.W(4)) u_sync (
        .clk  (core_clk),
        .rstn (rstn),
        .d    ({~slave_select_n_in, miso_in, mosi_in, link_done}), // inverted: reset reads idle
        .q    ({ss_act, miso_s, mosi_s, done_s})
    );

    // shared pin is the slave's miso in single-pin mode
    assign slave_din = cfg.single_pin_select ? miso_in : mosi_in;

    // ------------------------------------------------------------
    // slave shifter on the link clock
    // ------------------------------------------------------------
    sbf_slave_link u_link (
        .link_clk (serial_clock_pin_in),
        .rstn     (rstn),
        .select_n (slave_select_n_in),
        .din      (slave_din),
        .dout     (link_dout),
        .tx_byte  (slv_tx),
        .load_tgl (slv_load),
        .rx_byte  (link_rx),
        .done_tgl (link_done)
    );

    assign miso_out = link_dout;

    // ------------------------------------------------------------
    // power state decode
    // ------------------------------------------------------------
    // core clock gating is modelled as a hold of the master engine and of slave receive copies
    assign freeze    = (power.cpu_wait & cfg.stop_in_wait)
                     | power.cpu_stop_retain;
    assign run       = cfg.system_enable & ~freeze;
    assign is_master = cfg.master_select;
    assign done_seen = done_s != done_last;

    // fault only as an enabled master seeing select low
    assign fault_hit = cfg.system_enable & is_master
                     & cfg.mode_fault_enable & ss_act;

    // master samples the shared pin when single-pin is on
    assign mst_din   = cfg.single_pin_select ? mosi_s : miso_s;

    // ------------------------------------------------------------
    // master transfer engine
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_sh       = sh;
        next_samp     = samp;
        next_half     = half;
        next_edge_idx = edge_idx;
        next_sclk     = serial_clock_pin_out;
        mst_done      = 1'b0;
        case (st)
            ST_IDLE: begin
                if (run && is_master && !flags.transmit_empty_flag && !fault_hit) begin
                    next_st       = ST_XFER;
                    next_sh       = tx_buf;
                    next_half     = HALF_LOAD;
                    next_edge_idx = 5'h00;
                end
            end
            ST_XFER: begin
                // no divider activity while frozen, so the byte resumes
                if (run) begin
                    if (half != 3'h0) begin
                        next_half = half - 3'h1;
                    end else begin
                        next_half = HALF_LOAD;
                        next_sclk = ~serial_clock_pin_out;
                        if (!serial_clock_pin_out) begin
                            next_samp = mst_din;
                        end else begin
                            next_sh = {sh[6:0], samp};
                        end
                        if (edge_idx == LAST_EDGE) begin
                            next_st  = ST_IDLE;
                            mst_done = 1'b1;
                        end else begin
                            next_edge_idx = edge_idx + 5'h01;
                        end
                    end
                end
            end
            default: next_st = ST_IDLE;
        endcase
        // a fault drops the transfer at once and parks the clock
        if (fault_hit || !is_master) begin
            next_st   = ST_IDLE;
            next_sclk = 1'b0;
            mst_done  = 1'b0;
        end
        if (power.cpu_stop_lose) begin
            next_st   = ST_IDLE;
            next_sclk = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // receive event selection
    // ------------------------------------------------------------
    // slave byte ends wait in the toggle until the core runs again
    assign rx_evt = mst_done | (done_seen & run & ~is_master);
    assign rx_val = mst_done ? next_sh : link_rx;

    // ------------------------------------------------------------
    // configuration, flags and data register
    // ------------------------------------------------------------
    always_comb begin
        next_cfg       = cfg;
        next_flags     = flags;
        next_data      = data_register;
        next_tx_buf    = tx_buf;
        next_arm_rx    = arm_rx;
        next_arm_tx    = arm_tx;
        next_arm_mf    = arm_mf;
        next_done_last = done_last;
        next_slv_tx    = slv_tx;
        next_slv_load  = slv_load;

        // software writes control
        if (cfg_wr) next_cfg = cfg_in;

        // status read arms the clear of each set flag
        if (status_rd) begin
            next_arm_rx = flags.receive_full_flag;
            next_arm_tx = flags.transmit_empty_flag;
            next_arm_mf = flags.mode_fault_flag;
        end

        // clears by the documented access pairs
        if (cfg_wr && arm_mf) begin
            next_flags.mode_fault_flag = 1'b0;
            next_arm_mf                = 1'b0;
        end
        if (data_rd && arm_rx) begin
            next_flags.receive_full_flag = 1'b0;
            next_flags.match_flag        = 1'b0;
            next_arm_rx                  = 1'b0;
        end

        // data writes fill the transmit buffer
        if (data_wr) begin
            next_tx_buf = data_wdata;
            if (arm_tx) begin
                next_flags.transmit_empty_flag = 1'b0;
                next_arm_tx                    = 1'b0;
            end
            if (!is_master) begin
                next_slv_tx   = data_wdata;
                next_slv_load = ~slv_load;
            end
        end

        // master moved the buffer into the shifter
        if (st == ST_IDLE && next_st == ST_XFER) begin
            next_flags.transmit_empty_flag = 1'b1;
        end

        // byte received; ignored while the last one is unread
        if (rx_evt) begin
            if (!is_master) begin
                next_done_last                 = done_s;
                next_flags.transmit_empty_flag = 1'b1;
            end
            if (!flags.receive_full_flag) begin
                next_data                    = rx_val;
                next_flags.receive_full_flag = 1'b1;
                next_flags.match_flag        = rx_val == match_value;
            end
        end

        // fault wins over any software clear in the same cycle; a losing stop still resets it
        if (fault_hit) begin
            next_flags.mode_fault_flag = 1'b1;
            next_cfg.master_select     = 1'b0;
            if (cfg.single_pin_select) begin
                next_cfg.shared_pin_output_enable = 1'b0;
            end
        end
        // keep the fault flag clear whenever a master has detection off
        if (!cfg.mode_fault_enable && is_master) begin
            next_flags.mode_fault_flag = 1'b0;
        end

        // state-losing stop returns config, flags, data, transmit buffer and arms to reset values
        if (power.cpu_stop_lose) begin
            next_cfg       = CFG_RST;
            next_flags     = FLAGS_RST;
            next_data      = RST_BYTE;
            next_tx_buf    = RST_BYTE;
            next_arm_rx    = 1'b0;
            next_arm_tx    = 1'b0;
            next_arm_mf    = 1'b0;
            next_done_last = done_s;
        end
    end

    // ------------------------------------------------------------
    // interrupt, wake and pin enables
    // ------------------------------------------------------------
    always_comb begin
        // fault interrupt tracks its flag level directly
        next_irq = cfg.system_enable & (
              (cfg.receive_fault_int_mask
                 & (flags.receive_full_flag | flags.mode_fault_flag))
            | (cfg.transmit_int_mask & flags.transmit_empty_flag)
            | (cfg.match_int_mask & flags.match_flag));
        // registered wake: sleeping slave sees a finished byte
        next_wake = cfg.system_enable & ~is_master & freeze
                  & cfg.receive_fault_int_mask & done_seen;
        next_sclk_oe = cfg.system_enable & is_master & ~fault_hit;
        next_mosi_oe = next_sclk_oe
                     & (~cfg.single_pin_select | cfg.shared_pin_output_enable);
        // the faulted slave keeps its output buffer off
        next_miso_oe = cfg.system_enable & ~is_master & ss_act
                     & ~flags.mode_fault_flag
                     & (~cfg.single_pin_select | cfg.shared_pin_output_enable);
        if (power.cpu_stop_lose) begin
            next_irq     = 1'b0;
            next_wake    = 1'b0;
            next_sclk_oe = 1'b0;
            next_mosi_oe = 1'b0;
            next_miso_oe = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st                   <= ST_IDLE;
            sh                   <= RST_BYTE;
            samp                 <= 1'b0;
            half                 <= 3'h0;
            edge_idx             <= 5'h00;
            serial_clock_pin_out <= 1'b0;
            cfg                  <= CFG_RST;
            flags                <= FLAGS_RST;
            data_register        <= RST_BYTE;
            tx_buf               <= RST_BYTE;
            arm_rx               <= 1'b0;
            arm_tx               <= 1'b0;
            arm_mf               <= 1'b0;
            done_last            <= 1'b0;
            slv_tx               <= RST_BYTE;
            slv_load             <= 1'b0;
            irq                  <= 1'b0;
            wake_irq             <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            mosi_oe              <= 1'b0;
            miso_oe              <= 1'b0;
        end else begin
            st                   <= next_st;
            sh                   <= next_sh;
            samp                 <= next_samp;
            half                 <= next_half;
            edge_idx             <= next_edge_idx;
            serial_clock_pin_out <= next_sclk;
            cfg                  <= next_cfg;
            flags                <= next_flags;
            data_register        <= next_data;
            tx_buf               <= next_tx_buf;
            arm_rx               <= next_arm_rx;
            arm_tx               <= next_arm_tx;
            arm_mf               <= next_arm_mf;
            done_last            <= next_done_last;
            slv_tx               <= next_slv_tx;
            slv_load             <= next_slv_load;
            irq                  <= next_irq;
            wake_irq             <= next_wake;
            serial_clock_pin_oe  <= next_sclk_oe;
            mosi_oe              <= next_mosi_oe;
            miso_oe              <= next_miso_oe;
        end
    end

    // master data leaves from the shifter top bit
    assign mosi_out = sh[7];

endmodule

`default_nettype wire

// ### sbf_spi_core_asserts.sv
// port checker for the spi fault and low-power block
`default_nettype none
module sbf_chk import sbf_pkg::*; (
    // clock, reset, software view and pin enables
    input wire logic       core_clk, rstn, irq, mosi_oe, miso_oe, serial_clock_pin_oe,
    input wire logic       slave_select_n_in,
    input wire logic [7:0] data_register,
    input wire sbf_cfg_t   cfg,
    input wire sbf_flags_t flags,
    input wire sbf_power_t power
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // armed master seeing its select pulled low
    sequence fault_cause;
        cfg.master_select && cfg.mode_fault_enable && cfg.system_enable && !slave_select_n_in;
    endsequence
    fault_set_a: assert property (fault_cause |-> ##[1:4] flags.mode_fault_flag)
        else $error("fault missed");
    fault_why_a: assert property ($rose(flags.mode_fault_flag)
        |-> $past(cfg.master_select && cfg.mode_fault_enable)) else $error("bad fault");
    fault_off_a: assert property (flags.mode_fault_flag && $past(flags.mode_fault_flag)
        |-> !(cfg.master_select || serial_clock_pin_oe || mosi_oe || miso_oe
        || cfg.single_pin_select && cfg.shared_pin_output_enable)) else $error("pins driven");
    irq_gate_a: assert property (!cfg.system_enable && !$past(cfg.system_enable)
        |-> !irq) else $error("irq while off");
    irq_fault_a: assert property (cfg.system_enable && cfg.receive_fault_int_mask
        && flags.mode_fault_flag |-> ##[0:1] irq) else $error("fault irq missing");
    // a full receiver ignores later bytes
    data_hold_a: assert property (flags.receive_full_flag && $past(flags.receive_full_flag)
        && !$past(power.cpu_stop_lose) |-> $stable(data_register)) else $error("data overrun");
    data_copy_a: assert property ($changed(data_register)
        |-> flags.receive_full_flag || $past(power.cpu_stop_lose)) else $error("stray copy");
    lose_reset_a: assert property (power.cpu_stop_lose
        |=> cfg == CFG_RST && data_register == RST_BYTE) else $error("no reset");
endmodule
bind sbf_spi_core sbf_chk u_chk (.*);
`default_nettype wire

// ### sbf_ext_master.sv
// external spi master model, mode 0, msb first
`default_nettype none
module sbf_ext_master (
    // serial clock, data and select towards the block
    output logic sclk, mosi, ss_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands low and select high between frames
    initial {sclk, mosi, ss_n} = 3'h3;
    task xfer(input logic [7:0] tx);
        #7 ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        mosi = ~mosi; // released line shows the inverse, not the last bit
        #16 ss_n = 1'b1;
    endtask
    // select held low with no clock, as a rival master would
    task hold(input int t);
        ss_n = 1'b0;
        #t ss_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### sbf_spi_core_tb_top.sv
// self-checking bench for the spi fault and low-power block
`default_nettype none
module sbf_spi_core_tb_top import sbf_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, status_rd = 1'b0, data_wr = 1'b0;
    logic data_rd = 1'b0, irq, wake_irq, mosi_out, mosi_oe, miso_out, miso_oe, m_mosi;
    logic serial_clock_pin_in, slave_select_n_in, serial_clock_pin_out, serial_clock_pin_oe;
    logic [7:0] data_wdata = 8'h00, match_value = 8'h3C, data_register;
    sbf_cfg_t   cfg_in = CFG_RST, cfg;
    sbf_power_t power = '0;
    sbf_flags_t flags;
    int         num_errors = 0, tests_run = 0;
    // far slave answers each master bit inverted; idle pins follow the model
    wire logic  mosi_in = mosi_oe ? mosi_out : m_mosi, miso_in = miso_oe ? miso_out : ~mosi_out;
    wire logic [15:0] snap = {irq, wake_irq, cfg.master_select, mosi_oe, flags, data_register};
    always #10 core_clk = ~core_clk;
    sbf_ext_master m (.sclk(serial_clock_pin_in), .mosi(m_mosi), .ss_n(slave_select_n_in));
    sbf_spi_core dut (.*);
    // drives land 2 ns after a rising edge
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // one-cycle strobe carrying a config word or data byte
    task automatic put(ref logic s, input logic [8:0] v);
        cfg_in = v;
        data_wdata = v[7:0];
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        num_errors += int'(got !== exp);
        if (got !== exp)
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    endtask
    task complete_run;
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog far past the roughly 125 cycles the tests take
    initial begin
        #100us num_errors++;
        complete_run;
    end
    initial begin
        cyc(10);
        rstn = 1'b1;
        chk(snap, {4'h0, FLAGS_RST, RST_BYTE});
        $display("reset test done");
        put(cfg_wr, 9'h183);
        put(status_rd, 9'h0C3);
        put(data_wr, 9'h0C3);
        for (int i = 0; i < 300 && flags.receive_full_flag !== 1'b1; i++)
            cyc(1);
        cyc(2);
        chk(snap, 16'hBE3C);
        match_value = 8'h00;
        put(status_rd, 9'h000);
        put(data_rd, 9'h000);
        chk(snap, 16'hB23C);
        chk({14'h0, serial_clock_pin_oe, serial_clock_pin_out}, 16'h0002);
        $display("master test done");
        put(cfg_wr, 9'h1F4);
        m.hold(200);
        chk(snap, 16'h833C);
        chk({15'h0, serial_clock_pin_oe}, 16'h0000);
        put(status_rd, 9'h10C);
        put(cfg_wr, 9'h10C);
        cyc(1);
        chk(snap, 16'h023C);
        power.cpu_wait = 1'b1;
        m.xfer(8'hA5);
        cyc(6);
        chk(snap, 16'h423C);
        power.cpu_wait = 1'b0;
        cyc(8);
        chk(snap, 16'h8AA5);
        chk({15'h0, miso_out}, 16'h0001);
        $display("fault and slave tests done");
        power.cpu_stop_lose = 1'b1;
        cyc(1);
        power.cpu_stop_lose = 1'b0;
        cyc(1);
        chk(snap, {4'h0, FLAGS_RST, RST_BYTE});
        chk({7'h00, cfg}, {7'h00, CFG_RST});
        $display("stop test done");
        complete_run;
    end
endmodule
`default_nettype wire
